/* File: logic/ppf_pin_mux.sv */
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
// How it works
// R1 - PA3 field bits 7:6, 11 gives analog three
// R2 - PA2 field bits 5:4, 11 gives analog two
// R3 - PA1 field: 10 analog one, 11 reference
// R4 - PA0 field bits 1:0, 11 gives analog zero
// R5 - PA6 field code 11 drives timer output
// R6 - PA5 field code 11 drives inverted output
// R7 - Second register bits 7:6,1:0 read zero
// R8 - Capture input from PA4 or PA5
// R9 - Timer clock from PA3 or PB4
// R10 - Interrupt one from PA4 or PB3
// R11 - Interrupt zero from PA3 or PB2
// R12 - Software sets direction input for these inputs
// R13 - Software selects pin before enabling peripheral
// R14 - Software disables peripheral before reselecting pin
// R15 - Reset sets all latches and directions high
// R16 - Output pins drive their data latch
// R17 - Bit operations read, modify, write whole port
// R18 - Falling edge on enabled PA pin wakes
// R19 - Direction one input, zero output reading latch
// R20 - Wake only for GPIO input during sleep
// R21 - PA6 code 00 also selects GPIO
// R22 - Selection registers reset to zero
module ppf_pin_mux (
  input  wire logic               SYS_CLK,
  input  wire logic               SYS_RST,
  input  wire ppf_pkg::ppf_req_t  REG_REQ,
  output logic [7:0]              REG_RDATA,
  input  wire logic [7:0]         PA_IN,
  output ppf_pkg::ppf_drive_t     PA_DRV,
  input  wire logic [7:0]         PB_IN,
  output ppf_pkg::ppf_drive_t     PB_DRV,
  input  wire logic               TIMER_OUT_TRUE,
  input  wire logic               TIMER_OUT_INVERTED,
  output logic                    TIMER_EXT_CLOCK_IN,
  output logic                    TIMER_CAPTURE_IN,
  output logic                    EXT_IRQ_ZERO,
  output logic                    EXT_IRQ_ONE,
  output logic [3:0]              ANALOG_IN_EN,
  output logic                    VREF_IN_EN,
  input  wire logic               SLEEP_IDLE,
  output logic                    WAKE_UP
);

  // Port read: pin level for inputs, latch for outputs
  function automatic logic [7:0] port_read(
    input logic [7:0] dir,
    input logic [7:0] pins,
    input logic [7:0] latch
  );
    // R19 input or latch
    port_read = (dir & pins) | (~dir & latch);
  endfunction : port_read

  // Read-modify-write of one bit of the whole port
  function automatic logic [7:0] bit_op(
    input logic [7:0] cur,
    input logic [7:0] word
  );
    logic [7:0] res;
    res = cur;
    res[word[2:0]] = word[ppf_pkg::BITOP_SET_BIT];
    bit_op = res;
  endfunction : bit_op

  // Two-bit field keeps the pin as GPIO unless code 11 (pin 1 also leaves GPIO on code 10)
  function automatic logic not_11(input logic [1:0] code);
    not_11 = (code != ppf_pkg::CODE_11);
  endfunction : not_11

  logic [7:0] sel_low_q;
  logic [7:0] sel_high_q;
  logic [7:0] in_sel_q;
  logic [7:0] pa_latch_q;
  logic [7:0] pa_dir_q;
  logic [7:0] pa_wake_q;
  logic [7:0] pb_latch_q;
  logic [7:0] pb_dir_q;
  logic [7:0] pa_prev_q;
  logic [7:0] rdata_d;
  logic [7:0] pa_gpio;
  logic [7:0] pa_out_d;
  logic [7:0] pa_oen_d;
  logic [7:0] pa_rd;
  logic [7:0] pb_rd;
  logic [1:0] f0;
  logic [1:0] f1;
  logic [1:0] f2;
  logic [1:0] f3;
  logic [1:0] f5;
  logic [1:0] f6;
  logic       wr_en;

  assign wr_en = REG_REQ.wr;
  assign f0 = sel_low_q[ppf_pkg::PIN0_LSB +: 2];
  assign f1 = sel_low_q[ppf_pkg::PIN1_LSB +: 2];
  assign f2 = sel_low_q[ppf_pkg::PIN2_LSB +: 2];
  assign f3 = sel_low_q[ppf_pkg::PIN3_LSB +: 2];
  assign f5 = sel_high_q[ppf_pkg::PIN5_LSB +: 2];
  assign f6 = sel_high_q[ppf_pkg::PIN6_LSB +: 2];
  assign pa_rd = port_read(pa_dir_q, PA_IN, pa_latch_q);
  assign pb_rd = port_read(pb_dir_q, PB_IN, pb_latch_q);

  // Selection registers
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      // R22 select reset
      sel_low_q  <= ppf_pkg::SEL_RST;
      sel_high_q <= ppf_pkg::SEL_RST;
      in_sel_q   <= ppf_pkg::SEL_RST;
    end else if (wr_en) begin
      case (REG_REQ.addr)
        ppf_pkg::ADR_SEL_LOW: begin
          sel_low_q <= REG_REQ.wdata;
        end
        ppf_pkg::ADR_SEL_HIGH: begin
          // R7 unused bits held zero
          sel_high_q <= REG_REQ.wdata & ppf_pkg::SEL_HIGH_MASK;
        end
        ppf_pkg::ADR_IN_SEL: begin
          // R22 upper bits zero
          in_sel_q <= REG_REQ.wdata & ppf_pkg::IN_SEL_MASK;
        end
        default: begin
          sel_low_q <= sel_low_q;
        end
      endcase
    end
  end

  // Port A registers
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      // R15 latches and directions high
      pa_latch_q <= ppf_pkg::LATCH_RST;
      pa_dir_q   <= ppf_pkg::DIR_RST;
      pa_wake_q  <= ppf_pkg::WAKE_RST;
    end else if (wr_en) begin
      case (REG_REQ.addr)
        ppf_pkg::ADR_PA_DATA: begin
          pa_latch_q <= REG_REQ.wdata;
        end
        ppf_pkg::ADR_PA_DIR: begin
          pa_dir_q <= REG_REQ.wdata;
        end
        ppf_pkg::ADR_PA_WAKE: begin
          pa_wake_q <= REG_REQ.wdata;
        end
        ppf_pkg::ADR_PA_BITOP: begin
          // R17 whole port rewritten
          pa_latch_q <= bit_op(pa_rd, REG_REQ.wdata);
        end
        default: begin
          pa_latch_q <= pa_latch_q;
        end
      endcase
    end
  end

  // Port B registers
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      // R15 port B defaults
      pb_latch_q <= ppf_pkg::LATCH_RST;
      pb_dir_q   <= ppf_pkg::DIR_RST;
    end else if (wr_en) begin
      case (REG_REQ.addr)
        ppf_pkg::ADR_PB_DATA: begin
          pb_latch_q <= REG_REQ.wdata;
        end
        ppf_pkg::ADR_PB_DIR: begin
          pb_dir_q <= REG_REQ.wdata;
        end
        ppf_pkg::ADR_PB_BITOP: begin
          // R17 whole port rewritten
          pb_latch_q <= bit_op(pb_rd, REG_REQ.wdata);
        end
        default: begin
          pb_latch_q <= pb_latch_q;
        end
      endcase
    end
  end

  // Read data mux
  always_comb begin
    rdata_d = 8'h00;
    if (REG_REQ.rd) begin
      case (REG_REQ.addr)
        ppf_pkg::ADR_SEL_LOW: begin
          rdata_d = sel_low_q;
        end
        // R7 read as zero
        ppf_pkg::ADR_SEL_HIGH: begin
          rdata_d = sel_high_q & ppf_pkg::SEL_HIGH_MASK;
        end
        ppf_pkg::ADR_IN_SEL: begin
          rdata_d = in_sel_q & ppf_pkg::IN_SEL_MASK;
        end
        // R19 pin or latch
        ppf_pkg::ADR_PA_DATA: begin
          rdata_d = pa_rd;
        end
        ppf_pkg::ADR_PA_DIR: begin
          rdata_d = pa_dir_q;
        end
        ppf_pkg::ADR_PA_WAKE: begin
          rdata_d = pa_wake_q;
        end
        ppf_pkg::ADR_PB_DATA: begin
          rdata_d = pb_rd;
        end
        ppf_pkg::ADR_PB_DIR: begin
          rdata_d = pb_dir_q;
        end
        default: begin
          rdata_d = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      REG_RDATA <= 8'h00;
    end else begin
      REG_RDATA <= rdata_d;
    end
  end

  // Port A function per pin
  always_comb begin
    // R4 pin 0 field
    pa_gpio[0] = not_11(f0);
    // R3 pin 1 field
    pa_gpio[1] = (f1 != ppf_pkg::CODE_10) && not_11(f1);
    // R2 pin 2 field
    pa_gpio[2] = not_11(f2);
    // R1 pin 3 field
    pa_gpio[3] = not_11(f3);
    pa_gpio[4] = 1'b1;
    pa_gpio[5] = not_11(f5);
    // R21 codes 00 to 10 GPIO
    pa_gpio[6] = not_11(f6);
    pa_gpio[7] = 1'b1;
    // R16 GPIO output drives latch
    pa_out_d = pa_latch_q;
    pa_oen_d = pa_dir_q | ~pa_gpio;
    // R6 inverted timer output
    if (!not_11(f5)) begin
      pa_out_d[5] = TIMER_OUT_INVERTED;
      pa_oen_d[5] = 1'b0;
    end
    // R5 true timer output
    if (!not_11(f6)) begin
      pa_out_d[6] = TIMER_OUT_TRUE;
      pa_oen_d[6] = 1'b0;
    end
  end

  // Port A pin drivers
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      PA_DRV.dout <= ppf_pkg::LATCH_RST;
      PA_DRV.oe_n <= ppf_pkg::DIR_RST;
    end else begin
      PA_DRV.dout <= pa_out_d;
      PA_DRV.oe_n <= pa_oen_d;
    end
  end

  // Port B pin drivers
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      PB_DRV.dout <= ppf_pkg::LATCH_RST;
      PB_DRV.oe_n <= ppf_pkg::DIR_RST;
    end else begin
      // R16 port B latch drive
      PB_DRV.dout <= pb_latch_q;
      PB_DRV.oe_n <= pb_dir_q;
    end
  end

  // Analog and reference enables
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ANALOG_IN_EN <= 4'h0;
      VREF_IN_EN   <= 1'b0;
    end else begin
      ANALOG_IN_EN[0] <= !not_11(f0);
      ANALOG_IN_EN[1] <= (f1 == ppf_pkg::CODE_10);
      ANALOG_IN_EN[2] <= !not_11(f2);
      ANALOG_IN_EN[3] <= !not_11(f3);
      // R3 reference input
      VREF_IN_EN      <= !not_11(f1);
    end
  end

  // Peripheral input routing
  // R8 capture source
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      TIMER_CAPTURE_IN <= 1'b0;
    end else begin
      TIMER_CAPTURE_IN <= in_sel_q[ppf_pkg::CAPT_BIT] ? PA_IN[5] : PA_IN[4];
    end
  end

  // R9 timer clock source
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      TIMER_EXT_CLOCK_IN <= 1'b0;
    end else begin
      TIMER_EXT_CLOCK_IN <= in_sel_q[ppf_pkg::TCLK_BIT] ? PB_IN[4] : PA_IN[3];
    end
  end

  // R10 interrupt one source
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      EXT_IRQ_ONE <= 1'b0;
    end else begin
      EXT_IRQ_ONE <= in_sel_q[ppf_pkg::IRQ1_BIT] ? PB_IN[3] : PA_IN[4];
    end
  end

  // R11 interrupt zero source
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      EXT_IRQ_ZERO <= 1'b0;
    end else begin
      EXT_IRQ_ZERO <= in_sel_q[ppf_pkg::IRQ0_BIT] ? PB_IN[2] : PA_IN[3];
    end
  end

  // Falling edge wake-up on port A
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pa_prev_q <= 8'hFF;
      WAKE_UP   <= 1'b0;
    end else begin
      pa_prev_q <= PA_IN;
      // R18 R20 enabled GPIO input fall
      WAKE_UP <= SLEEP_IDLE
                 && |(pa_prev_q & ~PA_IN & pa_wake_q & pa_gpio & pa_dir_q);
    end
  end

endmodule : ppf_pin_mux

/* File: logic/ppf_pkg.sv */
package ppf_pkg;

  // Register index on the plain register port
  localparam logic [3:0] ADR_SEL_LOW   = 4'h0;
  localparam logic [3:0] ADR_SEL_HIGH  = 4'h1;
  localparam logic [3:0] ADR_IN_SEL    = 4'h2;
  localparam logic [3:0] ADR_PA_DATA   = 4'h3;
  localparam logic [3:0] ADR_PA_DIR    = 4'h4;
  localparam logic [3:0] ADR_PA_WAKE   = 4'h5;
  localparam logic [3:0] ADR_PB_DATA   = 4'h6;
  localparam logic [3:0] ADR_PB_DIR    = 4'h7;
  localparam logic [3:0] ADR_PA_BITOP  = 4'h8;
  localparam logic [3:0] ADR_PB_BITOP  = 4'h9;

  // Field positions, select registers
  localparam int PIN0_LSB = 0;
  localparam int PIN1_LSB = 2;
  localparam int PIN2_LSB = 4;
  localparam int PIN3_LSB = 6;
  localparam int PIN5_LSB = 2;
  localparam int PIN6_LSB = 4;
  localparam int IRQ0_BIT = 0;
  localparam int IRQ1_BIT = 1;
  localparam int TCLK_BIT = 2;
  localparam int CAPT_BIT = 3;

  // Writable bits of the narrow registers
  localparam logic [7:0] SEL_HIGH_MASK = 8'h3C;
  localparam logic [7:0] IN_SEL_MASK   = 8'h0F;

  // Bit operation word layout
  localparam int BITOP_SET_BIT = 3;

  // Reset values
  localparam logic [7:0] SEL_RST   = 8'h00;
  localparam logic [7:0] LATCH_RST = 8'hFF;
  localparam logic [7:0] DIR_RST   = 8'hFF;
  localparam logic [7:0] WAKE_RST  = 8'h00;

  // Field codes
  localparam logic [1:0] CODE_10 = 2'b10;
  localparam logic [1:0] CODE_11 = 2'b11;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } ppf_req_t;

  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe_n;
  } ppf_drive_t;

endpackage : ppf_pkg

/* File: sim/ppf_pin_mux_monitor.sv */
`timescale 1ns/1ps
module ppf_pin_mux_monitor (
  input wire logic               SYS_CLK,
  input wire logic               SYS_RST,
  input wire ppf_pkg::ppf_req_t  REG_REQ,
  input wire logic [7:0]         REG_RDATA,
  input wire logic [7:0]         PA_IN,
  input wire ppf_pkg::ppf_drive_t PA_DRV,
  input wire logic [7:0]         PB_IN,
  input wire logic               TIMER_OUT_TRUE,
  input wire logic               TIMER_OUT_INVERTED,
  input wire logic               TIMER_EXT_CLOCK_IN,
  input wire logic               TIMER_CAPTURE_IN,
  input wire logic               EXT_IRQ_ZERO,
  input wire logic               EXT_IRQ_ONE,
  input wire logic [3:0]         ANALOG_IN_EN,
  input wire logic               VREF_IN_EN
);
  logic [7:0] sl_q, sh_q, is_q;
  logic       ok_q;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  // Shadow of the selection registers
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      {sl_q, sh_q, is_q, ok_q} <= '0;
    end else begin
      ok_q <= 1'b1;
      if (REG_REQ.wr && REG_REQ.addr == ppf_pkg::ADR_SEL_LOW) sl_q <= REG_REQ.wdata;
      if (REG_REQ.wr && REG_REQ.addr == ppf_pkg::ADR_SEL_HIGH)
        sh_q <= REG_REQ.wdata & ppf_pkg::SEL_HIGH_MASK;
      if (REG_REQ.wr && REG_REQ.addr == ppf_pkg::ADR_IN_SEL)
        is_q <= REG_REQ.wdata & ppf_pkg::IN_SEL_MASK;
    end
  end
  high_read_a: assert property (REG_REQ.rd && REG_REQ.addr == ppf_pkg::ADR_SEL_HIGH
    |=> REG_RDATA == sh_q) else $error("sel high readback");
  insel_read_a: assert property (REG_REQ.rd && REG_REQ.addr == ppf_pkg::ADR_IN_SEL
    |=> REG_RDATA == is_q) else $error("input select readback");
  analog_sel_a: assert property (ok_q |-> ANALOG_IN_EN == $past({&sl_q[7:6],
    &sl_q[5:4], sl_q[3:2] == 2'b10, &sl_q[1:0]})) else $error("analog enables");
  vref_sel_a: assert property (ok_q |-> VREF_IN_EN == $past(&sl_q[3:2]))
    else $error("reference enable");
  capture_src_a: assert property (ok_q |-> TIMER_CAPTURE_IN ==
    $past(is_q[3] ? PA_IN[5] : PA_IN[4])) else $error("capture routing");
  tclk_src_a: assert property (ok_q |-> TIMER_EXT_CLOCK_IN ==
    $past(is_q[2] ? PB_IN[4] : PA_IN[3])) else $error("timer clock routing");
  irq_one_a: assert property (ok_q |-> EXT_IRQ_ONE ==
    $past(is_q[1] ? PB_IN[3] : PA_IN[4])) else $error("irq one routing");
  irq_zero_a: assert property (ok_q |-> EXT_IRQ_ZERO ==
    $past(is_q[0] ? PB_IN[2] : PA_IN[3])) else $error("irq zero routing");
  pa6_timer_a: assert property (ok_q && $past(&sh_q[5:4]) |-> !PA_DRV.oe_n[6] &&
    PA_DRV.dout[6] == $past(TIMER_OUT_TRUE)) else $error("pin 6 timer drive");
  pa5_timer_a: assert property (ok_q && $past(&sh_q[3:2]) |-> !PA_DRV.oe_n[5] &&
    PA_DRV.dout[5] == $past(TIMER_OUT_INVERTED)) else $error("pin 5 timer drive");
endmodule : ppf_pin_mux_monitor

/* File: sim/ppf_pin_mux_tb.sv */
`timescale 1ns/1ps
module ppf_pin_mux_tb;
  logic clk = 0, rst = 1, to = 0, ti = 0, slp = 0;
  ppf_pkg::ppf_req_t req = '0;
  logic [7:0] pa = 8'hA5, pb = 8'h5A, rdata, sl, sh, is_, pal, pad, wk, pbl, pbd;
  ppf_pkg::ppf_drive_t pa_drv, pb_drv;
  logic [3:0] ana;
  logic [15:0] n;
  logic tclk, cap, irq0, irq1, vref, wake;
  int failures = 0, checked = 0;
  ppf_pin_mux dut_u (.SYS_CLK(clk), .SYS_RST(rst), .REG_REQ(req), .REG_RDATA(rdata),
    .PA_IN(pa), .PA_DRV(pa_drv), .PB_IN(pb), .PB_DRV(pb_drv), .TIMER_OUT_TRUE(to),
    .TIMER_OUT_INVERTED(ti), .TIMER_EXT_CLOCK_IN(tclk), .TIMER_CAPTURE_IN(cap),
    .EXT_IRQ_ZERO(irq0), .EXT_IRQ_ONE(irq1), .ANALOG_IN_EN(ana), .VREF_IN_EN(vref),
    .SLEEP_IDLE(slp), .WAKE_UP(wake));
  task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task summarize;
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  function logic [7:0] bop(input logic [7:0] p, dr, l, w);
    bop = (dr & p) | (~dr & l);
    bop[w[2:0]] = w[3];
  endfunction : bop
  task do_rst;
    if (!rst) @(posedge clk);
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    {sl, sh, is_, wk} = '0;
    {pal, pad, pbl, pbd} = '1;
    @(posedge clk);
    #1 chk("pa_drv", pa_drv, 16'hFFFF);
    chk("pb_drv", pb_drv, 16'hFFFF);
  endtask : do_rst
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, a, d};
    case (a)
      ppf_pkg::ADR_SEL_LOW: sl = d;
      ppf_pkg::ADR_SEL_HIGH: sh = d & ppf_pkg::SEL_HIGH_MASK;
      ppf_pkg::ADR_IN_SEL: is_ = d & ppf_pkg::IN_SEL_MASK;
      ppf_pkg::ADR_PA_DATA: pal = d;
      ppf_pkg::ADR_PA_DIR: pad = d;
      ppf_pkg::ADR_PA_WAKE: wk = d;
      ppf_pkg::ADR_PB_DATA: pbl = d;
      ppf_pkg::ADR_PB_DIR: pbd = d;
      ppf_pkg::ADR_PA_BITOP: pal = bop(pa, pad, pal, d);
      ppf_pkg::ADR_PB_BITOP: pbl = bop(pb, pbd, pbl, d);
      default: ;
    endcase
    @(posedge clk);
    req <= '0;
  endtask : wr
  task rd(input logic [3:0] a);
    logic [7:0] e;
    e = 8'h00;
    case (a)
      ppf_pkg::ADR_SEL_LOW: e = sl;
      ppf_pkg::ADR_SEL_HIGH: e = sh;
      ppf_pkg::ADR_IN_SEL: e = is_;
      ppf_pkg::ADR_PA_DATA: e = (pad & pa) | (~pad & pal);
      ppf_pkg::ADR_PA_DIR: e = pad;
      ppf_pkg::ADR_PA_WAKE: e = wk;
      ppf_pkg::ADR_PB_DATA: e = (pbd & pb) | (~pbd & pbl);
      ppf_pkg::ADR_PB_DIR: e = pbd;
      default: ;
    endcase
    @(posedge clk);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    req <= '0;
    #1 chk("rdata", rdata, e);
  endtask : rd
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    #200000;
    failures++;
    summarize();
  end
  initial begin
    void'($urandom(66008));
    do_rst();
    for (int a = 0; a < 11; a++) rd(a[3:0]);
    for (int a = 0; a < 11; a++) begin
      wr(a[3:0], 8'($urandom));
      rd(a[3:0]);
      chk("pb_drv", pb_drv, {pbl, pbd});
    end
    do_rst();
    wr(ppf_pkg::ADR_PA_DIR, 8'h00);
    repeat (2) @(posedge clk);
    #1 chk("pa_high", pa_drv, 16'hFF00);
    rd(ppf_pkg::ADR_PA_DATA);
    wr(ppf_pkg::ADR_PA_DIR, 8'h0F);
    wr(ppf_pkg::ADR_PA_BITOP, 8'h06);
    repeat (2) @(posedge clk);
    #1 chk("bitop", pa_drv, {pal, 8'h0F});
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      pa <= 8'($urandom);
      pb <= 8'($urandom);
      to <= 1'b0;
      ti <= 1'b0;
      wr(ppf_pkg::ADR_SEL_LOW, {4{i[1:0]}});
      wr(ppf_pkg::ADR_SEL_HIGH, {4{i[3:2]}});
      wr(ppf_pkg::ADR_IN_SEL, i[7:0]);
      to <= 1'($urandom);
      ti <= 1'($urandom);
      repeat (2) @(posedge clk);
      #1 chk("analog", {ana, vref}, {&sl[7:6], &sl[5:4], sl[3:2] == 2'b10, &sl[1:0], &sl[3:2]});
      chk("route", {tclk, cap, irq1, irq0}, {is_[2] ? pb[4] : pa[3], is_[3] ? pa[5] : pa[4],
        is_[1] ? pb[3] : pa[4], is_[0] ? pb[2] : pa[3]});
      chk("pa56", {pa_drv.dout[6:5], pa_drv.oe_n[6:5]},
        i[3:2] == 2'b11 ? {to, ti, 2'b00} : {pal[6:5], pad[6:5]});
      rd(ppf_pkg::ADR_IN_SEL);
    end
    wr(ppf_pkg::ADR_SEL_LOW, 8'h00);
    wr(ppf_pkg::ADR_PA_DIR, 8'hFF);
    wr(ppf_pkg::ADR_PA_WAKE, 8'h01);
    for (int s = 0; s < 3; s++) begin
      @(posedge clk);
      pa <= 8'hFF;
      slp <= s != 1;
      repeat (3) @(posedge clk);
      pa <= s == 2 ? 8'hFD : 8'hFE;
      n = 16'h0000;
      repeat (5) begin
        @(posedge clk);
        #1 n = n + wake;
      end
      chk("wake", n, {15'h0000, s == 0});
    end
    do_rst();
    rd(ppf_pkg::ADR_SEL_HIGH);
    summarize();
  end
endmodule : ppf_pin_mux_tb
bind ppf_pin_mux ppf_pin_mux_monitor mon_u (.SYS_CLK, .SYS_RST, .REG_REQ, .REG_RDATA, .PA_IN,
  .PA_DRV, .PB_IN, .TIMER_OUT_TRUE, .TIMER_OUT_INVERTED, .TIMER_EXT_CLOCK_IN,
  .TIMER_CAPTURE_IN, .EXT_IRQ_ZERO, .EXT_IRQ_ONE, .ANALOG_IN_EN, .VREF_IN_EN);
